// ===== rtl/awr_pkg.sv
// Shared constants and types of the converter result and window register block.
package awr_pkg;

  // ************************************************************
  // Bus and register map
  // ************************************************************
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  localparam int NPAIR = 4;
  localparam logic [7:0] OFS_RESULT = 8'h10;
  localparam logic [7:0] OFS_SAMPLE = 8'h14;
  localparam logic [7:0] OFS_TEMP = 8'h18;
  localparam logic [7:0] OFS_WIN_LO = 8'h1c;
  localparam logic [7:0] OFS_WIN_HI = 8'h1e;
  localparam logic [7:0] OFS_CFG = 8'h20;
  localparam logic [7:0] OFS_STATUS = 8'h21;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int CFG_CNT_LSB = 0;
  localparam int CFG_CNT_W = 3;
  localparam int CFG_LEFT_BIT = 4;
  localparam int CFG_WATCH_BIT = 5;
  localparam int ST_ABOVE_BIT = 0;
  localparam int ST_BELOW_BIT = 1;
  localparam int ST_INSIDE_BIT = 2;
  localparam int ST_RDY_BIT = 3;
  localparam logic [7:0] CFG_WR_MASK = 8'h37;

  // ************************************************************
  // Reset values and counts
  // ************************************************************
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [2:0] CNT_MAX_SEL = 3'h6;
  localparam int RAW_W_DEF = 10;
  localparam int CNT_W = 7;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [1:0] {PAIR_RESULT, PAIR_SAMPLE, PAIR_WIN_LO, PAIR_WIN_HI} awr_pair_t;
  typedef enum logic {BUS_IDLE, BUS_ANS} awr_bus_state_t;
  typedef enum logic {ACC_IDLE, ACC_RUN} awr_acc_state_t;

endpackage : awr_pkg

// ===== rtl/awr_acc_if.sv
// Link between the register block and its sample accumulator.
`timescale 1ns/10ps
`default_nettype none
interface awr_acc_if #(parameter int RAW_W = 10);
  logic [2:0] count_sel;
  logic left_align;
  logic raw_valid;
  logic [RAW_W-1:0] raw;
  logic [15:0] sample_word;
  logic sample_upd;
  logic [15:0] result_word;
  logic result_upd;

  modport regs (output count_sel, left_align, raw_valid, raw,
                input sample_word, sample_upd, result_word, result_upd);
  modport accum (input count_sel, left_align, raw_valid, raw,
                 output sample_word, sample_upd, result_word, result_upd);
endinterface : awr_acc_if
`default_nettype wire

// ===== rtl/awr_accum.sv
// Sample alignment and accumulation engine feeding the register block.
`timescale 1ns/10ps
`default_nettype none
module awr_accum (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic nrst,
  // Link to the register block.
  awr_acc_if.accum acc
);
  import awr_pkg::*;

  localparam int RW = $bits(acc.raw);

  awr_acc_state_t state_r, state_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic [CNT_W-1:0] target_r, target_nxt;
  logic [15:0] sum_r, sum_nxt;
  logic [15:0] sample_r, result_r;
  logic sample_upd_r, result_upd_r;
  logic [15:0] aligned;
  logic [CNT_W-1:0] sel_target;
  logic done;

  // Aligned form of the newest raw sample.
  assign aligned = acc.left_align ? {acc.raw, {(16-RW){1'b0}}} : 16'(acc.raw);
  // Reserved count codes fall back to a single sample.
  assign sel_target = (acc.count_sel > CNT_MAX_SEL) ? CNT_W'(1) : CNT_W'(1) << acc.count_sel;

  // Accumulation sequence; the count is latched at the first sample so a change mid-run cannot tear it.
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    target_nxt = target_r;
    sum_nxt = sum_r;
    done = 1'b0;
    case (state_r)
      ACC_IDLE: begin
        if (acc.raw_valid) begin
          target_nxt = sel_target;
          sum_nxt = 16'(acc.raw);
          cnt_nxt = CNT_W'(1);
          done = (sel_target == CNT_W'(1));
          state_nxt = done ? ACC_IDLE : ACC_RUN;
        end
      end
      ACC_RUN: begin
        if (acc.raw_valid) begin
          sum_nxt = sum_r + 16'(acc.raw);
          cnt_nxt = cnt_r + CNT_W'(1);
          done = (cnt_nxt == target_r);
          state_nxt = done ? ACC_IDLE : ACC_RUN;
        end
      end
      default: begin
        state_nxt = ACC_IDLE;
      end
    endcase
  end

  // State and sum registers.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= ACC_IDLE;
      cnt_r <= '0;
      target_r <= CNT_W'(1);
      sum_r <= RST_WORD;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      target_r <= target_nxt;
      sum_r <= sum_nxt;
    end
  end

  // Newest sample always published; result only once the whole run is summed.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      sample_r <= RST_WORD;
      result_r <= RST_WORD;
      sample_upd_r <= 1'b0;
      result_upd_r <= 1'b0;
    end else begin
      sample_upd_r <= acc.raw_valid;
      result_upd_r <= done;
      if (acc.raw_valid) begin
        sample_r <= aligned;
      end
      if (done) begin
        result_r <= (target_nxt == CNT_W'(1)) ? aligned : sum_nxt;
      end
    end
  end

  assign acc.sample_word = sample_r;
  assign acc.sample_upd = sample_upd_r;
  assign acc.result_word = result_r;
  assign acc.result_upd = result_upd_r;

endmodule : awr_accum
`default_nettype wire

// ===== rtl/awr_regs.sv
// Converter result, sample, byte latch and window threshold registers on Avalon-MM.
//
// What this block does
// - Sample held as low/high byte pair.
// - One byte latch serves all 16-bit pairs.
// - Byte latch directly readable and writable.
// - Sixteen-bit lower window threshold byte pair.
// - Sixteen-bit upper window threshold byte pair.
// - Accumulated result compared only when final.
// - Result low byte holds result bits 7:0.
// - Sample, latch and thresholds reset zero.
// - Accumulate 1..64 samples; newest sample kept.
// - Left-align sample, and single-sample result, when alignment bit set.
`timescale 1ns/10ps
`default_nettype none
module awr_regs #(
  parameter int RAW_W = awr_pkg::RAW_W_DEF
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic nrst,
  // Avalon-MM slave.
  input wire logic [awr_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [awr_pkg::DATA_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [awr_pkg::DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  // Converter core, same clock.
  input wire logic conv_valid,
  input wire logic [RAW_W-1:0] conv_raw,
  // Window comparator and result status.
  output logic result_ready,
  output logic window_upd,
  output logic win_above,
  output logic win_below,
  output logic win_inside
);
  import awr_pkg::*;

  // ************************************************************
  // Address decoding helpers
  // ************************************************************

  // Pairs start on even addresses, so address bit 0 alone picks the byte within a pair.
  // True when the address falls on one byte of a 16-bit pair.
  function automatic logic is_pair(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] base;
    base = {a[ADDR_W-1:1], 1'b0};
    return (base == OFS_RESULT) || (base == OFS_SAMPLE) || (base == OFS_WIN_LO) || (base == OFS_WIN_HI);
  endfunction : is_pair

  // Which pair the address selects; only meaningful when is_pair holds.
  function automatic awr_pair_t pair_idx(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] base;
    awr_pair_t p;
    base = {a[ADDR_W-1:1], 1'b0};
    p = PAIR_RESULT;
    if (base == OFS_SAMPLE) begin
      p = PAIR_SAMPLE;
    end else if (base == OFS_WIN_LO) begin
      p = PAIR_WIN_LO;
    end else if (base == OFS_WIN_HI) begin
      p = PAIR_WIN_HI;
    end
    return p;
  endfunction : pair_idx

  // ************************************************************
  // Bus handshake
  // ************************************************************
  awr_bus_state_t bus_r, bus_nxt;
  logic req;
  logic go;
  logic wr_go;
  logic rd_go;

  // Every access answers in its second cycle; the extra cycle lets read data come from a flop.
  // A write with byte lane 0 off, or to an unmapped address, is still answered but changes nothing.
  assign req = avs_read | avs_write;
  assign avs_waitrequest = req & (bus_r == BUS_IDLE);
  assign go = req & (bus_r == BUS_ANS);
  assign wr_go = go & avs_write & avs_byteenable[0];
  assign rd_go = go & avs_read;

  // Two-state answer sequencer.
  always_comb begin
    bus_nxt = bus_r;
    case (bus_r)
      BUS_IDLE: begin
        if (req) begin
          bus_nxt = BUS_ANS;
        end
      end
      BUS_ANS: begin
        bus_nxt = BUS_IDLE;
      end
      default: begin
        bus_nxt = BUS_IDLE;
      end
    endcase
  end

  // Sequencer state register.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      bus_r <= BUS_IDLE;
    end else begin
      bus_r <= bus_nxt;
    end
  end

  // ************************************************************
  // Accumulator link
  // ************************************************************
  awr_acc_if #(.RAW_W(RAW_W)) acc ();
  logic [7:0] cfg_r;

  assign acc.count_sel = cfg_r[CFG_CNT_LSB +: CFG_CNT_W];
  assign acc.left_align = cfg_r[CFG_LEFT_BIT];
  assign acc.raw_valid = conv_valid;
  assign acc.raw = conv_raw;

  awr_accum u_accum (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .acc(acc)
  );

  // ************************************************************
  // Decoded write and read strobes
  // ************************************************************
  logic addr_pair;
  logic addr_hi;
  awr_pair_t addr_idx;
  logic pair_wr_lo;
  logic pair_wr_hi;
  logic pair_rd_lo;
  logic temp_wr;
  logic cfg_wr;
  logic status_wr;
  logic [7:0] wbyte;

  assign addr_pair = is_pair(avs_address);
  assign addr_idx = pair_idx(avs_address);
  assign addr_hi = avs_address[0];
  assign wbyte = avs_writedata[7:0];
  assign pair_wr_lo = wr_go & addr_pair & ~addr_hi;
  assign pair_wr_hi = wr_go & addr_pair & addr_hi;
  assign pair_rd_lo = rd_go & addr_pair & ~addr_hi;
  assign temp_wr = wr_go & (avs_address == OFS_TEMP);
  assign cfg_wr = wr_go & (avs_address == OFS_CFG);
  assign status_wr = wr_go & (avs_address == OFS_STATUS);

  // ************************************************************
  // Sixteen-bit register pairs
  // ************************************************************
  logic [15:0] pair_r [NPAIR];
  logic [15:0] hw_val [NPAIR];
  logic [NPAIR-1:0] hw_upd;
  logic [7:0] temp_r;

  // Only result and sample are refreshed by the converter; thresholds belong to software.
  // Their hardware inputs are tied off, so nothing but a bus commit can move them.
  assign hw_val[PAIR_RESULT] = acc.result_word;
  assign hw_val[PAIR_SAMPLE] = acc.sample_word;
  assign hw_val[PAIR_WIN_LO] = RST_WORD;
  assign hw_val[PAIR_WIN_HI] = RST_WORD;
  assign hw_upd = {1'b0, 1'b0, acc.sample_upd, acc.result_upd};

  // One pair register per slot; the high-byte write commits the latched low byte with it.
  // A software commit wins over a converter update in the same cycle, so a test write is not lost.
  for (genvar gi = 0; gi < NPAIR; gi++) begin : g_pair
    logic commit;
    assign commit = pair_wr_hi & (addr_idx == awr_pair_t'(gi));
    always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
        pair_r[gi] <= RST_WORD;
      end else if (commit) begin
        pair_r[gi] <= {wbyte, temp_r};
      end else if (hw_upd[gi]) begin
        pair_r[gi] <= hw_val[gi];
      end
    end
  end

  // Shared byte latch: low-byte writes park data here, low-byte reads park the high byte here.
  // Only one access is on the bus at a time, so the priority order below is never contested.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      temp_r <= RST_BYTE;
    end else if (temp_wr) begin
      temp_r <= wbyte;
    end else if (pair_wr_lo) begin
      temp_r <= wbyte;
    end else if (pair_rd_lo) begin
      temp_r <= pair_r[addr_idx][15:8];
    end
  end

  // ************************************************************
  // Configuration
  // ************************************************************

  // Count select, alignment and which value the window watches.
  // Reserved bits are masked on write so they always read back as zero.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cfg_r <= RST_BYTE;
    end else if (cfg_wr) begin
      cfg_r <= wbyte & CFG_WR_MASK;
    end
  end

  // ************************************************************
  // Window comparator
  // ************************************************************
  logic watch_sample;
  logic watch_upd;
  logic [15:0] watch_val;
  logic cmp_above;
  logic cmp_below;
  logic above_r, below_r, inside_r, wupd_r, rdy_pulse_r, rdy_r;

  // The compare uses the freshly produced word, so a same-cycle threshold write is seen next time.
  // Inverted thresholds are not refused: a value between them reports above and below together,
  // which software can use to spot a bad setup.
  assign watch_sample = cfg_r[CFG_WATCH_BIT];
  assign watch_upd = watch_sample ? acc.sample_upd : acc.result_upd;
  assign watch_val = watch_sample ? acc.sample_word : acc.result_word;
  assign cmp_above = watch_val > pair_r[PAIR_WIN_HI];
  assign cmp_below = watch_val < pair_r[PAIR_WIN_LO];

  // Comparator flags hold until the next watched update.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      above_r <= 1'b0;
      below_r <= 1'b0;
      inside_r <= 1'b0;
      wupd_r <= 1'b0;
    end else begin
      wupd_r <= watch_upd;
      if (watch_upd) begin
        above_r <= cmp_above;
        below_r <= cmp_below;
        inside_r <= ~cmp_above & ~cmp_below;
      end
    end
  end

  // Sticky result-ready flag, cleared by writing one; a new result in the clear cycle wins.
  // The pulse output trails the update by one cycle, so it lines up with the refreshed flags.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rdy_r <= 1'b0;
      rdy_pulse_r <= 1'b0;
    end else begin
      rdy_pulse_r <= acc.result_upd;
      if (acc.result_upd) begin
        rdy_r <= 1'b1;
      end else if (status_wr & wbyte[ST_RDY_BIT]) begin
        rdy_r <= 1'b0;
      end
    end
  end

  assign result_ready = rdy_pulse_r;
  assign window_upd = wupd_r;
  assign win_above = above_r;
  assign win_below = below_r;
  assign win_inside = inside_r;

  // ************************************************************
  // Read path
  // ************************************************************
  logic [7:0] status_byte;
  logic [7:0] rd_byte;
  logic [DATA_W-1:0] rdata_r;

  assign status_byte = {4'h0, rdy_r, inside_r, below_r, above_r};
  // High bytes of a pair return the latch, which the preceding low-byte read filled.
  // Anything not decoded reads as zero, so software can probe the map safely.
  assign rd_byte = addr_pair ? (addr_hi ? temp_r : pair_r[addr_idx][7:0]) :
                   (avs_address == OFS_TEMP) ? temp_r :
                   (avs_address == OFS_CFG) ? cfg_r :
                   (avs_address == OFS_STATUS) ? status_byte : 8'h00;

  // Read data is captured in the waiting cycle so it stands when waitrequest drops.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rdata_r <= '0;
    end else if (avs_read & (bus_r == BUS_IDLE)) begin
      rdata_r <= {24'h000000, rd_byte};
    end
  end

  assign avs_readdata = rdata_r;

endmodule : awr_regs
`default_nettype wire

// ===== tb/awr_regs_asserts.sv
// Concurrent port checks for the converter result and window register block.
`timescale 1ns/10ps
`default_nettype none
module awr_regs_asserts #(
  parameter int RAW_W = awr_pkg::RAW_W_DEF
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic nrst,
  // Avalon-MM slave.
  input wire logic [awr_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [awr_pkg::DATA_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [awr_pkg::DATA_W-1:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Converter core.
  input wire logic conv_valid,
  input wire logic [RAW_W-1:0] conv_raw,
  // Comparator and status.
  input wire logic result_ready,
  input wire logic window_upd,
  input wire logic win_above,
  input wire logic win_below,
  input wire logic win_inside
);
  import awr_pkg::*;

  // ************************************************************
  // Checks
  // ************************************************************
  // Everything runs on one clock, so one default clocking serves all checks.
  default clocking dclk @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);

  // Each request waits exactly one cycle before it is answered.
  a_wait_first_cycle: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
    else $error("waitrequest low in the first cycle of a request");
  a_wait_one_cycle: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered after one wait cycle");
  // Registers are bytes, so the upper read lanes stay clear.
  a_rdata_upper_zero: assert property (avs_readdata[31:8] == 24'h0)
    else $error("upper read data lanes not zero");
  // Read data may only move after the wait cycle of a read.
  a_rdata_stands: assert property ($changed(avs_readdata) |-> $past(avs_read && avs_waitrequest))
    else $error("read data changed without a read");
  // A finished result follows its last sample by two cycles.
  a_ready_cause: assert property (result_ready |-> $past(conv_valid, 2))
    else $error("result ready without a sample two cycles earlier");
  a_upd_cause: assert property (window_upd |-> $past(conv_valid, 2))
    else $error("comparator refresh without a sample two cycles earlier");
  // Flags are levels that only move on a comparator refresh.
  a_flags_hold: assert property (!window_upd |-> $stable({win_above, win_below, win_inside}))
    else $error("window flags moved without a refresh");
  a_flags_onehot: assert property (window_upd |-> $onehot({win_above, win_below, win_inside}))
    else $error("window flags not exactly one after refresh");
endmodule : awr_regs_asserts

bind awr_regs awr_regs_asserts #(.RAW_W(RAW_W)) u_awr_regs_asserts (
  .ref_clk(ref_clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .conv_valid(conv_valid),
  .conv_raw(conv_raw), .result_ready(result_ready), .window_upd(window_upd),
  .win_above(win_above), .win_below(win_below), .win_inside(win_inside)
);
`default_nettype wire

// ===== tb/tb_awr_regs.sv
// Self-checking bench for the converter result and window register block.
`timescale 1ns/10ps
`default_nettype none
module tb_awr_regs;
  import awr_pkg::*;
  localparam int RW = 10;

  // ************************************************************
  // Signals and design
  // ************************************************************
  logic ref_clk = 1'h0;
  logic nrst = 1'h0;
  logic [ADDR_W-1:0] avs_address = 8'h0;
  logic avs_read = 1'h0;
  logic avs_write = 1'h0;
  logic [DATA_W-1:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'h0;
  logic [DATA_W-1:0] avs_readdata;
  logic avs_waitrequest;
  logic conv_valid = 1'h0;
  logic [RW-1:0] conv_raw = 10'h0;
  logic result_ready, window_upd, win_above, win_below, win_inside;
  int bad_count = 0;
  int n_checks = 0;
  logic [7:0] rb;
  logic [RW-1:0] raws [64];
  logic [7:0] tbl [4] = '{OFS_RESULT, OFS_SAMPLE, OFS_WIN_LO, OFS_WIN_HI};

  always #12.5 ref_clk = ~ref_clk;

  awr_regs #(.RAW_W(RW)) u_awr_regs (
    .ref_clk(ref_clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .conv_valid(conv_valid),
    .conv_raw(conv_raw), .result_ready(result_ready), .window_upd(window_upd),
    .win_above(win_above), .win_below(win_below), .win_inside(win_inside)
  );

  // ************************************************************
  // Helpers
  // ************************************************************
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : give_verdict

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk16

  task automatic chk_flags(input logic [2:0] got, input logic [2:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t window flags got %b exp %b", $time, got, exp);
    end
  endtask : chk_flags

  // One bus cycle; waitrequest and read data are read right after each rising edge, before that
  // edge's updates land, so they are the values the design saw; release follows that same edge.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    int n;
    n = 0;
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_byteenable <= 4'h1;
    avs_read <= !wr;
    avs_write <= wr;
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'h0 && n < 100);
    if (n >= 100) begin
      bad_count++;
      $display("MISMATCH t=%0t bus cycle never answered", $time);
    end
    q = avs_readdata[7:0];
    avs_read <= 1'h0;
    avs_write <= 1'h0;
  endtask : bus

  // Pairs go low byte first so the latch carries the low half.
  task automatic wr16(input logic [7:0] a, input logic [15:0] v);
    bus(1'h1, a, v[7:0], rb);
    bus(1'h1, a + 8'h1, v[15:8], rb);
  endtask : wr16

  task automatic rd16(input logic [7:0] a, output logic [15:0] v);
    logic [7:0] lo;
    bus(1'h0, a, 8'h0, lo);
    bus(1'h0, a + 8'h1, 8'h0, rb);
    v = {rb, lo};
  endtask : rd16

  task automatic conv(input logic [RW-1:0] r);
    @(posedge ref_clk);
    conv_valid <= 1'h1;
    conv_raw <= r;
    @(posedge ref_clk);
    conv_valid <= 1'h0;
    conv_raw <= ~r;
  endtask : conv

  function automatic logic [15:0] align(input logic [RW-1:0] r, input logic left);
    return left ? (16'(r) << (16 - RW)) : 16'(r);
  endfunction : align

  // Both thresholds equal t, so inside means equal: {inside, below, above}.
  function automatic logic [2:0] exp_flags(input logic [15:0] m, input logic [15:0] t);
    return {m == t, m < t, m > t};
  endfunction : exp_flags

  // ************************************************************
  // Tests
  // ************************************************************
  // Whole run needs about 1200 cycles; the limit leaves a wide margin.
  initial begin
    repeat (20000) @(posedge ref_clk);
    bad_count++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    give_verdict();
  end

  initial begin
    logic [15:0] v, e, m, th, got;
    logic [2:0] sel;
    logic left, watch;
    int ns, k;
    void'($urandom(53812));
    repeat (4) @(posedge ref_clk);
    nrst <= 1'h1;
    foreach (tbl[i]) begin
      rd16(tbl[i], got);
      chk16(got, 16'h0, "reset pair");
    end
    bus(1'h0, OFS_TEMP, 8'h0, rb);
    chk16({8'h0, rb}, 16'h0, "reset latch");
    $display("test reset done");
    v = 16'($urandom());
    bus(1'h1, OFS_TEMP, v[7:0], rb);
    bus(1'h0, OFS_TEMP, 8'h0, rb);
    chk16({8'h0, rb}, {8'h0, v[7:0]}, "latch rw");
    bus(1'h1, 8'h30, 8'ha5, rb);
    bus(1'h0, 8'h30, 8'h0, rb);
    chk16({8'h0, rb}, 16'h0, "unmapped");
    for (int i = 1; i < 4; i++) begin
      v = 16'($urandom());
      wr16(tbl[i], v);
      rd16(tbl[i], got);
      chk16(got, v, "pair rw");
      bus(1'h0, OFS_TEMP, 8'h0, rb);
      chk16({8'h0, rb}, {8'h0, v[15:8]}, "latch copy");
    end
    bus(1'h1, OFS_TEMP, 8'h3c, rb);
    bus(1'h1, OFS_WIN_LO + 8'h1, 8'hc3, rb);
    rd16(OFS_WIN_LO, got);
    chk16(got, 16'hc33c, "high write commit");
    $display("test registers done");
    // Every count and both alignments; run 14 watches the sample, run 15 uses a reserved count code.
    for (int it = 0; it < 16; it++) begin
      sel = (it == 15) ? 3'h7 : (it == 14) ? 3'h3 : 3'(it % 7);
      left = (it >= 7);
      watch = (it == 14);
      ns = (sel > CNT_MAX_SEL) ? 1 : 1 << sel;
      e = 16'h0;
      for (k = 0; k < ns; k++) begin
        raws[k] = RW'($urandom_range(1023, 1));
        e = (ns == 1) ? align(raws[k], left) : e + 16'(raws[k]);
      end
      v = align(raws[ns-1], left);
      m = watch ? v : e;
      th = m + 16'(it % 3) - 16'h1;
      wr16(OFS_WIN_LO, th);
      wr16(OFS_WIN_HI, th);
      bus(1'h1, OFS_CFG, {2'h0, watch, left, 1'h0, sel}, rb);
      for (k = 0; k < ns; k++) begin
        conv(raws[k]);
      end
      k = 0;
      while (result_ready !== 1'h1 && k < 20) begin
        @(negedge ref_clk);
        k++;
      end
      chk16(16'(k < 20), 16'h1, "result ready");
      chk_flags({win_inside, win_below, win_above}, exp_flags(m, th));
      chk16(16'(window_upd), 16'h1, "flag refresh");
      bus(1'h0, OFS_STATUS, 8'h0, rb);
      chk16({8'h0, rb}, {8'h0, 4'h0, 1'h1, exp_flags(m, th)}, "status");
      bus(1'h1, OFS_STATUS, 8'h08, rb);
      rd16(OFS_RESULT, got);
      chk16(got, e, "result");
      rd16(OFS_SAMPLE, got);
      chk16(got, v, "sample");
      $display("test conversion %0d done", it);
    end
    give_verdict();
  end
endmodule : tb_awr_regs
`default_nettype wire
